// ---- shared/rffe_pkg.sv ----
package rffe_pkg;
	// Frame field widths
	localparam int SA_W = 4;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int CMD_BITS = 13;
	localparam int DATA_BITS = 9;
	// Command codes in the top three command bits
	localparam logic [2:0] CMD_WR = 3'h2;
	localparam logic [2:0] CMD_RD = 3'h3;
	// Register offsets
	localparam logic [4:0] REG_SWSEL = 5'h00;
	localparam logic [4:0] REG_GROUP = 5'h1B;
	localparam logic [4:0] REG_PWR = 5'h1C;
	// Reset values and broadcast slave identifier
	localparam logic [7:0] SWSEL_RST = 8'h00;
	localparam logic [3:0] GROUP_SLAVE_IDENTIFIER_RST = 4'h0;
	localparam logic [3:0] USID_RST = 4'hB;
	localparam logic [3:0] BCAST_SID = 4'h0;
	// Power-state codes
	localparam logic [1:0] PWR_ACTIVE = 2'h0;
	localparam logic [1:0] PWR_STARTUP = 2'h1;
	localparam logic [1:0] PWR_LOW = 2'h2;
	// Switch-select codes, throw one to six
	localparam logic [7:0] SEL_P1 = 8'h07;
	localparam logic [7:0] SEL_P2 = 8'h06;
	localparam logic [7:0] SEL_P3 = 8'h0B;
	localparam logic [7:0] SEL_P4 = 8'h0C;
	localparam logic [7:0] SEL_P5 = 8'h0A;
	localparam logic [7:0] SEL_P6 = 8'h04;
	// Link clock: clk cycles per half period (40 ns clk, 320 ns link)
	localparam int CLK_NS = 40;
	localparam int LINK_NS = 320;
	localparam int HALF_CYC = LINK_NS / CLK_NS / 2;
	// Controller register byte addresses
	localparam logic [3:0] HREG_CTRL = 4'h0;
	localparam logic [3:0] HREG_WDATA = 4'h4;
	localparam logic [3:0] HREG_STAT = 4'h8;
	// Controller order kinds
	localparam logic [1:0] KIND_WR = 2'h1;
	localparam logic [1:0] KIND_RD = 2'h2;
	localparam logic [1:0] KIND_R0 = 2'h3;
endpackage

// ---- shared/rffe_link_if.sv ----
`timescale 1ns/100ps
interface rffe_link_if;
	logic sclk;
	logic sdataMst;
	logic sdataMstOe;
	logic sdataSlv;
	logic sdataSlvOe;
	logic sdata;

	// Resolved data line; a weak keeper holds it low when nobody drives
	assign sdata = sdataMstOe ? sdataMst : (sdataSlvOe ? sdataSlv : 1'b0);

	modport master (
		output sclk, sdataMst, sdataMstOe,
		input sdata
	);
	modport slave (
		input sclk, sdata,
		output sdataSlv, sdataSlvOe
	);
endinterface

// ---- hdl/link_sync.sv ----
`timescale 1ns/100ps
module link_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Asynchronous in, synchronised out
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] stage1_r;

	// Two flops per bit
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (srst) begin
				stage1_r[i] <= 1'b0;
				dout[i] <= 1'b0;
			end else begin
				stage1_r[i] <= din[i];
				dout[i] <= stage1_r[i];
			end
		end
	end
endmodule

// ---- hdl/rffe_slave.sv ----
`timescale 1ns/100ps
// Behaviour
// - accept write, read and register-zero write
// - four-bit slave, five-bit address, eight-bit data
// - odd parity after each protected group
// - register-zero write: address, one, seven bits
// - register-zero write completes after park cycle
// - switch-select at zero, resets zero, no broadcast
// - power field 00 active, 01 startup, 10 low
// - power field resets low, accepts broadcast
// - in active state each of the six switch codes connects exactly one throw, other codes and other states none
module rffe_slave #(
	parameter logic [3:0] USID = rffe_pkg::USID_RST
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Link
	rffe_link_if.slave link,
	// Switch and power state
	output logic [5:0] throwPort,
	output logic [1:0] powerState,
	output logic [7:0] switchSel
);
	typedef enum {S_IDLE, S_CMD, S_WDATA, S_PARK, S_TURN, S_RDATA} state_t;

	state_t state_r;
	logic [1:0] syncIn;
	logic sclkS, sdataS;
	logic sclkPrev_r, sdataPrev_r;
	logic riseE, fallE, sdataRise, sdataFall;
	logic armed_r;
	logic [3:0] cnt_r;
	logic [12:0] shIn_r, cmdBits;
	logic [8:0] dataBits, shOut_r;
	logic isOwn, isGroup, isBcast;
	logic cmdParOk, cmdIsR0, cmdIsWr, cmdIsRd;
	logic bcast_r, r0Wr_r;
	logic [4:0] addr_r;
	logic [7:0] wdata_r, swSel_r, rdVal;
	logic doWrite;
	logic [3:0] group_slave_identifier_r;
	logic [1:0] pwr_r;
	logic sdOut_r, sdOe_r;
	logic [5:0] throw_r;

	// Pins pass two flops before use
	link_sync #(.W(2)) u_sync (
		.clk(clk),
		.srst(srst),
		.din({link.sclk, link.sdata}),
		.dout(syncIn)
	);
	assign sclkS = syncIn[1];
	assign sdataS = syncIn[0];

	// Edge history of synchronised pins
	always_ff @(posedge clk) begin
		if (srst) begin
			sclkPrev_r <= 1'b0;
			sdataPrev_r <= 1'b0;
		end else begin
			sclkPrev_r <= sclkS;
			sdataPrev_r <= sdataS;
		end
	end
	assign riseE = sclkS & ~sclkPrev_r;
	assign fallE = ~sclkS & sclkPrev_r;
	assign sdataRise = sdataS & ~sdataPrev_r & ~sclkS;
	assign sdataFall = ~sdataS & sdataPrev_r & ~sclkS;

	// Incoming bit view, current bit included
	assign cmdBits = {shIn_r[11:0], sdataS};
	assign dataBits = {shIn_r[7:0], sdataS};

	// Command frame decode
	assign isBcast = cmdBits[12:9] == rffe_pkg::BCAST_SID;
	assign isOwn = cmdBits[12:9] == USID;
	assign isGroup = cmdBits[12:9] == group_slave_identifier_r;
	assign cmdParOk = ^cmdBits;
	assign cmdIsR0 = cmdBits[8];
	assign cmdIsWr = cmdBits[8:6] == rffe_pkg::CMD_WR;
	assign cmdIsRd = cmdBits[8:6] == rffe_pkg::CMD_RD;

	// Start condition: data pulses high while the clock is low
	always_ff @(posedge clk) begin
		if (srst) begin
			armed_r <= 1'b0;
		end else if (state_r != S_IDLE || sclkS) begin
			armed_r <= 1'b0;
		end else if (sdataRise) begin
			armed_r <= 1'b1;
		end
	end

	// Sequence state machine
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= S_IDLE;
			cnt_r <= 4'h0;
			shIn_r <= 13'h0000;
			bcast_r <= 1'b0;
			r0Wr_r <= 1'b0;
			addr_r <= 5'h00;
			wdata_r <= 8'h00;
		end else begin
			case (state_r)
				S_IDLE: begin
					cnt_r <= 4'h0;
					if (armed_r && sdataFall) begin
						state_r <= S_CMD;
					end
				end
				S_CMD: begin
					if (fallE) begin
						shIn_r <= cmdBits;
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == 4'(rffe_pkg::CMD_BITS - 1)) begin
							cnt_r <= 4'h0;
							bcast_r <= isBcast;
							addr_r <= cmdBits[5:1];
							if (!cmdParOk || !(isOwn || isGroup || isBcast)) begin
								state_r <= S_IDLE;
							end else if (cmdIsR0) begin
								r0Wr_r <= 1'b1;
								wdata_r <= {1'b0, cmdBits[7:1]};
								state_r <= S_PARK;
							end else if (cmdIsWr) begin
								r0Wr_r <= 1'b0;
								state_r <= S_WDATA;
							end else if (cmdIsRd && isOwn) begin
								state_r <= S_TURN;
							end else begin
								state_r <= S_IDLE;
							end
						end
					end
				end
				S_WDATA: begin
					if (fallE) begin
						shIn_r <= {4'h0, dataBits};
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == 4'(rffe_pkg::DATA_BITS - 1)) begin
							wdata_r <= dataBits[8:1];
							state_r <= ^dataBits ? S_PARK : S_IDLE;
						end
					end
				end
				S_PARK: begin
					if (fallE) begin
						state_r <= S_IDLE;
					end
				end
				S_TURN: begin
					if (fallE) begin
						cnt_r <= 4'h0;
						state_r <= S_RDATA;
					end
				end
				S_RDATA: begin
					if (riseE) begin
						cnt_r <= cnt_r + 4'h1;
					end
					if (fallE && cnt_r == 4'(rffe_pkg::DATA_BITS + 1)) begin
						state_r <= S_IDLE;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// Register update fires at the park cycle's falling edge
	assign doWrite = state_r == S_PARK && fallE;

	// Switch-select register
	always_ff @(posedge clk) begin
		if (srst) begin
			swSel_r <= rffe_pkg::SWSEL_RST;
		end else if (doWrite && !bcast_r && r0Wr_r) begin
			swSel_r <= wdata_r;
		end else if (doWrite && !r0Wr_r && addr_r == rffe_pkg::REG_PWR
			&& wdata_r[7:6] == rffe_pkg::PWR_STARTUP) begin
			swSel_r <= rffe_pkg::SWSEL_RST;
		end else if (doWrite && !bcast_r && addr_r == rffe_pkg::REG_SWSEL) begin
			swSel_r <= wdata_r;
		end
	end

	// Group identifier register
	always_ff @(posedge clk) begin
		if (srst) begin
			group_slave_identifier_r <= rffe_pkg::GROUP_SLAVE_IDENTIFIER_RST;
		end else if (doWrite && !r0Wr_r && addr_r == rffe_pkg::REG_PWR
			&& wdata_r[7:6] == rffe_pkg::PWR_STARTUP) begin
			group_slave_identifier_r <= rffe_pkg::GROUP_SLAVE_IDENTIFIER_RST;
		end else if (doWrite && !r0Wr_r && !bcast_r
			&& addr_r == rffe_pkg::REG_GROUP) begin
			group_slave_identifier_r <= wdata_r[3:0];
		end
	end

	// Power-state field, broadcast writes allowed
	always_ff @(posedge clk) begin
		if (srst) begin
			pwr_r <= rffe_pkg::PWR_LOW;
		end else if (doWrite && !r0Wr_r && addr_r == rffe_pkg::REG_PWR) begin
			pwr_r <= wdata_r[7:6];
		end
	end

	// Read-back value
	always_comb begin
		case (addr_r)
			rffe_pkg::REG_SWSEL: rdVal = swSel_r;
			rffe_pkg::REG_GROUP: rdVal = {4'h0, group_slave_identifier_r};
			rffe_pkg::REG_PWR: rdVal = {pwr_r, 6'h00};
			default: rdVal = 8'h00;
		endcase
	end

	// Read data driven on rising edges, then park low and release
	always_ff @(posedge clk) begin
		if (srst) begin
			shOut_r <= 9'h000;
			sdOut_r <= 1'b0;
			sdOe_r <= 1'b0;
		end else if (state_r == S_TURN && fallE) begin
			shOut_r <= {rdVal, ~^rdVal};
		end else if (state_r == S_RDATA && riseE) begin
			sdOe_r <= 1'b1;
			sdOut_r <= cnt_r < 4'(rffe_pkg::DATA_BITS) ? shOut_r[8] : 1'b0;
			shOut_r <= {shOut_r[7:0], 1'b0};
		end else if (state_r == S_RDATA && fallE
			&& cnt_r == 4'(rffe_pkg::DATA_BITS + 1)) begin
			sdOe_r <= 1'b0;
			sdOut_r <= 1'b0;
		end
	end
	assign link.sdataSlv = sdOut_r;
	assign link.sdataSlvOe = sdOe_r;

	// Throw decode; all throws open unless active
	always_ff @(posedge clk) begin
		if (srst) begin
			throw_r <= 6'h00;
		end else if (pwr_r != rffe_pkg::PWR_ACTIVE) begin
			throw_r <= 6'h00;
		end else begin
			case (swSel_r)
				rffe_pkg::SEL_P1: throw_r <= 6'h01;
				rffe_pkg::SEL_P2: throw_r <= 6'h02;
				rffe_pkg::SEL_P3: throw_r <= 6'h04;
				rffe_pkg::SEL_P4: throw_r <= 6'h08;
				rffe_pkg::SEL_P5: throw_r <= 6'h10;
				rffe_pkg::SEL_P6: throw_r <= 6'h20;
				default: throw_r <= 6'h00;
			endcase
		end
	end
	assign throwPort = throw_r;
	assign powerState = pwr_r;
	assign switchSel = swSel_r;
endmodule

// ---- hdl/rffe_master.sv ----
`timescale 1ns/100ps
module rffe_master (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Link
	rffe_link_if.master link,
	// Avalon-MM slave
	input wire logic [3:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [31:0] avWritedata,
	output logic [31:0] avReaddata,
	output logic avWaitrequest
);
	typedef enum {H_IDLE, H_SSC, H_BITS, H_PARK, H_RTURN, H_RDATA,
		H_RPARK} hstate_t;

	hstate_t state_r;
	logic sdataS;
	logic wait_r;
	logic [31:0] rdata_r;
	logic ack;
	logic [1:0] kind_r;
	logic [3:0] sa_r;
	logic [4:0] addr_r;
	logic [7:0] wdata_r;
	logic busy_r;
	logic rdErr_r;
	logic [7:0] rdByte_r;
	logic [2:0] ph_r;
	logic [4:0] cnt_r;
	logic [4:0] nBits_r;
	logic [21:0] sh_r;
	logic [8:0] rsh_r;
	logic start;
	logic sclk_r;
	logic sdOut_r;
	logic sdOe_r;

	// Data pin from the far end
	link_sync #(.W(1)) u_sync (
		.clk(clk),
		.srst(srst),
		.din(link.sdata),
		.dout(sdataS)
	);

	// Bus answer one edge after the request is seen
	always_ff @(posedge clk) begin
		if (srst) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= !((avRead || avWrite) && wait_r);
		end
	end
	assign ack = (avRead || avWrite) && wait_r;
	assign start = ack && avWrite && avAddress == rffe_pkg::HREG_CTRL
		&& !busy_r && avWritedata[1:0] != 2'h0;

	// Register writes and read data
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_r <= 32'h0000_0000;
			kind_r <= 2'h0;
			sa_r <= 4'h0;
			addr_r <= 5'h00;
			wdata_r <= 8'h00;
		end else if (ack && avRead) begin
			case (avAddress)
				rffe_pkg::HREG_CTRL: rdata_r <= {19'h0, addr_r, sa_r, 2'h0, kind_r};
				rffe_pkg::HREG_WDATA: rdata_r <= {24'h0, wdata_r};
				rffe_pkg::HREG_STAT: rdata_r <= {16'h0, rdByte_r, 6'h0, rdErr_r,
					busy_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end else if (start) begin
			kind_r <= avWritedata[1:0];
			sa_r <= avWritedata[7:4];
			addr_r <= avWritedata[12:8];
		end else if (ack && avWrite && avAddress == rffe_pkg::HREG_WDATA
			&& !busy_r) begin
			wdata_r <= avWritedata[7:0];
		end
	end
	assign avWaitrequest = wait_r;
	assign avReaddata = rdata_r;

	// Sequencer; one link bit spans eight clk cycles
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= H_IDLE;
			busy_r <= 1'b0;
			rdErr_r <= 1'b0;
			rdByte_r <= 8'h00;
			ph_r <= 3'h0;
			cnt_r <= 5'h00;
			nBits_r <= 5'h00;
			sh_r <= 22'h0;
			rsh_r <= 9'h000;
			sclk_r <= 1'b0;
			sdOut_r <= 1'b0;
			sdOe_r <= 1'b0;
		end else begin
			ph_r <= state_r == H_IDLE ? 3'h0 : ph_r + 3'h1;
			if (state_r != H_IDLE && state_r != H_SSC) begin
				if (ph_r == 3'h0) begin
					sclk_r <= 1'b1;
				end else if (ph_r == 3'(rffe_pkg::HALF_CYC)) begin
					sclk_r <= 1'b0;
				end
			end
			case (state_r)
				H_IDLE: begin
					if (start) begin
						busy_r <= 1'b1;
						cnt_r <= 5'h00;
						case (avWritedata[1:0])
							rffe_pkg::KIND_WR: begin
								sh_r <= {{avWritedata[7:4], rffe_pkg::CMD_WR,
									avWritedata[12:8]},
									~^{avWritedata[7:4], rffe_pkg::CMD_WR,
									avWritedata[12:8]},
									wdata_r, ~^wdata_r};
								nBits_r <= 5'(rffe_pkg::CMD_BITS
									+ rffe_pkg::DATA_BITS);
							end
							rffe_pkg::KIND_RD: begin
								sh_r <= {{avWritedata[7:4], rffe_pkg::CMD_RD,
									avWritedata[12:8]},
									~^{avWritedata[7:4], rffe_pkg::CMD_RD,
									avWritedata[12:8]}, 9'h000};
								nBits_r <= 5'(rffe_pkg::CMD_BITS);
							end
							default: begin
								sh_r <= {avWritedata[7:4], 1'b1, wdata_r[6:0],
									~^{avWritedata[7:4], 1'b1, wdata_r[6:0]},
									9'h000};
								nBits_r <= 5'(rffe_pkg::CMD_BITS);
							end
						endcase
						state_r <= H_SSC;
					end
				end
				H_SSC: begin
					sdOe_r <= 1'b1;
					sdOut_r <= ph_r < 3'(rffe_pkg::HALF_CYC);
					if (ph_r == 3'h7) begin
						state_r <= H_BITS;
					end
				end
				H_BITS: begin
					if (ph_r == 3'h0) begin
						sdOut_r <= sh_r[21];
						sh_r <= {sh_r[20:0], 1'b0};
					end
					if (ph_r == 3'h7) begin
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == nBits_r - 5'h01) begin
							state_r <= kind_r == rffe_pkg::KIND_RD ? H_RTURN : H_PARK;
						end
					end
				end
				H_PARK, H_RTURN: begin
					if (ph_r == 3'h0) begin
						sdOut_r <= 1'b0;
					end else if (ph_r == 3'(rffe_pkg::HALF_CYC)) begin
						sdOe_r <= 1'b0;
					end
					if (ph_r == 3'h7) begin
						cnt_r <= 5'h00;
						busy_r <= state_r == H_RTURN;
						state_r <= state_r == H_RTURN ? H_RDATA : H_IDLE;
					end
				end
				H_RDATA: begin
					if (ph_r == 3'h7) begin
						rsh_r <= {rsh_r[7:0], sdataS};
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == 5'(rffe_pkg::DATA_BITS - 1)) begin
							state_r <= H_RPARK;
						end
					end
				end
				H_RPARK: begin
					if (ph_r == 3'h7) begin
						rdByte_r <= rsh_r[8:1];
						rdErr_r <= ~^rsh_r;
						busy_r <= 1'b0;
						state_r <= H_IDLE;
					end
				end
				default: begin
					state_r <= H_IDLE;
				end
			endcase
		end
	end
	assign link.sclk = sclk_r;
	assign link.sdataMst = sdOut_r;
	assign link.sdataMstOe = sdOe_r;
endmodule

// ---- tb/rffe_link_props.sv ----
`timescale 1ns/100ps
module rffe_link_props (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Link lines
	input wire logic sclk,
	input wire logic sdataMstOe,
	input wire logic sdataSlvOe,
	input wire logic sdata,
	// Slave state
	input wire logic [5:0] throwPort,
	input wire logic [1:0] powerState,
	input wire logic [7:0] switchSel
);
	logic [5:0] thrExp;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// Throw expected from the stored state
	always_comb begin
		case (switchSel)
			rffe_pkg::SEL_P1: thrExp = 6'h01;
			rffe_pkg::SEL_P2: thrExp = 6'h02;
			rffe_pkg::SEL_P3: thrExp = 6'h04;
			rffe_pkg::SEL_P4: thrExp = 6'h08;
			rffe_pkg::SEL_P5: thrExp = 6'h10;
			rffe_pkg::SEL_P6: thrExp = 6'h20;
			default: thrExp = 6'h00;
		endcase
		if (powerState != rffe_pkg::PWR_ACTIVE) thrExp = 6'h00;
	end

	// Link clock high phase and start condition
	sequence hiPhase;
		sclk[*4] ##1 !sclk;
	endsequence
	sequence startCond;
		sdata[*4] ##1 (!sdata)[*4] ##1 sclk;
	endsequence

	a_throw_map: assert property (
		1'b1 |=> throwPort == $past(thrExp))
		else $error("throw does not follow switch code");
	a_throw_onehot: assert property ($onehot0(throwPort))
		else $error("more than one throw on");
	a_power_gate: assert property (
		powerState != rffe_pkg::PWR_ACTIVE |=> throwPort == 6'h00)
		else $error("throw on outside active state");
	a_oe_exclusive: assert property (!(sdataMstOe && sdataSlvOe))
		else $error("both ends drive data");
	a_sclk_high: assert property ($rose(sclk) |-> hiPhase)
		else $error("link clock high phase wrong");
	a_sclk_low: assert property ($fell(sclk) |-> (!sclk)[*4])
		else $error("link clock low phase short");
	a_start_cond: assert property (
		$rose(sdata) && !sclk && sdataMstOe |-> startCond)
		else $error("start condition malformed");
	a_slave_drive: assert property (
		$rose(sdataSlvOe) |-> sclk && !sdataMstOe)
		else $error("slave drives at wrong time");
	a_master_park: assert property (
		$fell(sdataMstOe) |-> !sclk && $past(sdata) == 1'b0)
		else $error("master release without park");
	a_reg_quiet: assert property (
		$changed(switchSel) || $changed(powerState) |-> !sclk && !sdataMstOe)
		else $error("register changed before park");
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	logic clk, srst, avRead, avWrite, avWaitrequest;
	logic [3:0] avAddress;
	logic [31:0] avWritedata, avReaddata, rd;
	logic [5:0] throwPort, throwPortB;
	logic [1:0] powerState, powerStateB;
	logic [7:0] switchSel, switchSelB;
	logic [7:0] codes [6] = '{rffe_pkg::SEL_P1, rffe_pkg::SEL_P2,
		rffe_pkg::SEL_P3, rffe_pkg::SEL_P4, rffe_pkg::SEL_P5, rffe_pkg::SEL_P6};
	int failures, compares;
	rffe_link_if link();
	rffe_link_if linkB();

	// Two ends facing each other, plus a slave on a bench-driven link
	rffe_master rffe_master_inst (.clk(clk), .srst(srst), .link(link),
		.avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
		.avWritedata(avWritedata), .avReaddata(avReaddata),
		.avWaitrequest(avWaitrequest));
	rffe_slave rffe_slave_inst (.clk(clk), .srst(srst), .link(link),
		.throwPort(throwPort), .powerState(powerState), .switchSel(switchSel));
	rffe_slave rffe_slave_inst_b (.clk(clk), .srst(srst), .link(linkB),
		.throwPort(throwPortB), .powerState(powerStateB),
		.switchSel(switchSelB));
	rffe_link_props rffe_link_props_inst (.clk(clk), .srst(srst),
		.sclk(link.sclk), .sdataMstOe(link.sdataMstOe),
		.sdataSlvOe(link.sdataSlvOe), .sdata(link.sdata),
		.throwPort(throwPort), .powerState(powerState), .switchSel(switchSel));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task end_sim;
		$display("Compares %0d, failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// One Avalon access, held until waitrequest is seen low
	task av(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avAddress <= a;
		avWritedata <= d;
		avWrite <= wr;
		avRead <= !wr;
		do begin
			@(posedge clk);
		end while (avWaitrequest !== 1'b0);
		q = avReaddata;
		avWrite <= 1'b0;
		avRead <= 1'b0;
		@(posedge clk);
	endtask

	// Link order through the controller, then wait for idle
	task order(input logic [1:0] k, input logic [3:0] sa, input logic [4:0] ra,
		input logic [7:0] wd, output logic [31:0] st);
		av(1'b1, rffe_pkg::HREG_WDATA, {24'h0, wd}, st);
		av(1'b1, rffe_pkg::HREG_CTRL, {19'h0, ra, sa, 2'h0, k}, st);
		do begin
			av(1'b0, rffe_pkg::HREG_STAT, 32'h0, st);
		end while (st[0] !== 1'b0);
		repeat (8) @(posedge clk);
	endtask

	// Write frame with selectable parity faults (bit1 cmd, bit0 data)
	function automatic logic [21:0] frm(input logic [4:0] a,
		input logic [7:0] d, input logic [1:0] bad);
		logic [11:0] c;
		c = {rffe_pkg::USID_RST, rffe_pkg::CMD_WR, a};
		return {c, (~^c) ^ bad[1], d, (~^d) ^ bad[0]};
	endfunction

	// Bench as link master: start, bits MSB first, park
	task drvB(input logic [21:0] f);
		linkB.sdataMstOe <= 1'b1;
		linkB.sdataMst <= 1'b1;
		repeat (4) @(posedge clk);
		linkB.sdataMst <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 21; i >= -1; i--) begin
			linkB.sclk <= 1'b1;
			linkB.sdataMst <= (i >= 0) ? f[i] : 1'b0;
			repeat (4) @(posedge clk);
			linkB.sclk <= 1'b0;
			if (i < 0) linkB.sdataMstOe <= 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (8) @(posedge clk);
	endtask

	// Watchdog
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		end_sim;
	end

	// Test sequence
	initial begin
		{srst, avRead, avWrite, avAddress, avWritedata} = {3'b100, 36'h0};
		{linkB.sclk, linkB.sdataMst, linkB.sdataMstOe} = 3'b000;
		failures = 0;
		compares = 0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk("powerState", powerState, rffe_pkg::PWR_LOW);
		chk("switchSel", switchSel, rffe_pkg::SWSEL_RST);
		av(1'b0, 4'hC, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		order(rffe_pkg::KIND_WR, rffe_pkg::BCAST_SID, rffe_pkg::REG_PWR,
			8'h00, rd);
		chk("powerState", powerState, rffe_pkg::PWR_ACTIVE);
		for (int i = 0; i < 6; i++) begin
			order(rffe_pkg::KIND_WR, rffe_pkg::USID_RST, 5'h00, codes[i], rd);
			chk("throwPort", throwPort, 6'h01 << i);
			order(rffe_pkg::KIND_RD, rffe_pkg::USID_RST, 5'h00, 8'h00, rd);
			chk("readback", rd[15:8], codes[i]);
			chk("readParity", rd[1], 1'b0);
		end
		order(rffe_pkg::KIND_R0, rffe_pkg::USID_RST, 5'h00, 8'hFF, rd);
		chk("switchSel", switchSel, 8'h7F);
		chk("throwPort", throwPort, 6'h00);
		order(rffe_pkg::KIND_R0, rffe_pkg::USID_RST, 5'h00, 8'h0B, rd);
		chk("switchSel", switchSel, rffe_pkg::SEL_P3);
		av(1'b0, rffe_pkg::HREG_WDATA, 32'h0, rd);
		chk("wdataReg", rd, 32'h0000_000B);
		av(1'b0, rffe_pkg::HREG_CTRL, 32'h0, rd);
		chk("ctrlReg", rd, {19'h0, 5'h00, rffe_pkg::USID_RST, 2'h0,
			rffe_pkg::KIND_R0});
		order(rffe_pkg::KIND_WR, rffe_pkg::BCAST_SID, 5'h00, 8'h07, rd);
		chk("switchSel", switchSel, rffe_pkg::SEL_P3);
		order(rffe_pkg::KIND_WR, 4'h5, 5'h00, 8'h07, rd);
		chk("switchSel", switchSel, rffe_pkg::SEL_P3);
		order(rffe_pkg::KIND_WR, rffe_pkg::USID_RST, rffe_pkg::REG_GROUP,
			8'h05, rd);
		order(rffe_pkg::KIND_WR, 4'h5, 5'h00, 8'h07, rd);
		chk("switchSel", switchSel, rffe_pkg::SEL_P1);
		order(rffe_pkg::KIND_WR, rffe_pkg::USID_RST, rffe_pkg::REG_PWR,
			8'h80, rd);
		chk("throwPort", throwPort, 6'h00);
		order(rffe_pkg::KIND_RD, rffe_pkg::USID_RST, rffe_pkg::REG_PWR,
			8'h00, rd);
		chk("powerRead", rd[15:8], 8'h80);
		order(rffe_pkg::KIND_RD, rffe_pkg::BCAST_SID, rffe_pkg::REG_PWR,
			8'h00, rd);
		chk("bcastRead", rd[15:8], 8'h00);
		chk("bcastParity", rd[1], 1'b1);
		order(rffe_pkg::KIND_WR, rffe_pkg::USID_RST, rffe_pkg::REG_PWR,
			8'h40, rd);
		chk("powerState", powerState, rffe_pkg::PWR_STARTUP);
		chk("switchSel", switchSel, rffe_pkg::SWSEL_RST);
		order(rffe_pkg::KIND_RD, rffe_pkg::USID_RST, rffe_pkg::REG_GROUP,
			8'h00, rd);
		chk("groupRead", rd[15:8], {4'h0, rffe_pkg::GROUP_SLAVE_IDENTIFIER_RST});
		drvB(frm(5'h00, rffe_pkg::SEL_P2, 2'b10));
		drvB(frm(5'h00, rffe_pkg::SEL_P2, 2'b01));
		chk("switchSelB", switchSelB, rffe_pkg::SWSEL_RST);
		drvB(frm(5'h00, rffe_pkg::SEL_P2, 2'b00));
		chk("switchSelB", switchSelB, rffe_pkg::SEL_P2);
		end_sim;
	end
endmodule
